// >>> src/dbs_top.sv
// burst ordering, write timing, dll control and self refresh for one device
// assumes an apb master on pclk and commands decoded to one-hot ops
//
// Local design decisions: the address map and the APB register port.
`default_nettype none
module dbs_top #(
   parameter int WR_BL8_DLY = 8,
   parameter int REF_CYCLES = dbs_pkg::REF_CYC,
   parameter int SR_PERIOD = dbs_pkg::REFI_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dbs_pkg::dbs_cmd_type cmd,
   output logic cmd_ready,
   output dbs_pkg::dbs_beat_type beat,
   output logic wr_int_start,
   output logic dll_en,
   output logic sr_active,
   output logic refresh_abort
);
   import dbs_pkg::*;

   localparam int WBL8 = WR_BL8_DLY;
   localparam int WBC4 = WR_BL8_DLY - WR_PULL_IN;

   initial begin
      if (WR_BL8_DLY < WR_PULL_IN + 2 || WR_BL8_DLY > 255) begin
         $error("dbs_top: WR_BL8_DLY out of range");
      end
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BURST = 2'b10
   } dbs_state_type;

   // unmapped offsets answer with an error and read as zero
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == ADDR_MODE) || (a == ADDR_DLL) || (a == ADDR_SRCTL) ||
                 (a == ADDR_STATUS) || (a == ADDR_REFCNT);
   endfunction

   logic [4:0] mode_reg;
   logic dll_reg;
   logic abort_reg;
   dbs_state_type state_reg;
   logic [2:0] k_reg;
   logic [2:0] st_col_reg;
   logic rd_reg;
   logic chop_reg;
   logic ilv_reg;
   logic [7:0] wr_timer_reg;
   logic [31:0] rdata_next;
   logic [2:0] beat_col;
   logic ref_busy;
   logic [15:0] ref_count;
   logic apb_wr;
   logic apb_setup;
   logic accept;
   logic is_rw;
   logic chop_next;
   logic fixed4;
   logic fixed8;
   logic otf;

   // apb decode; every access finishes in its first access cycle, no wait states
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite && addr_hit(paddr);
   assign pready = psel && penable;
   assign pslverr = psel && penable && !addr_hit(paddr);

   // length decode; the spare code behaves as unchopped eight-beat
   assign fixed4 = mode_reg[BL_LSB +: 2] == BL_FIX4;
   assign fixed8 = mode_reg[BL_LSB +: 2] == BL_FIX8;
   assign otf = mode_reg[BL_LSB +: 2] == BL_OTF;
   assign is_rw = (cmd.op == OP_READ) || (cmd.op == OP_WRITE);
   // a running burst or self refresh refuses new column commands
   assign cmd_ready = (state_reg == ST_IDLE) && !sr_active; // [R22]
   assign accept = cmd.valid && is_rw && cmd_ready;
   // fixed length from the mode field, otherwise the command's own bit
   assign chop_next = fixed4 || (otf && !cmd.bl8_sel); // [R2] [R3]
   assign dll_en = dll_reg;

   // mode register: length, type, crc
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_RST;
      end else if (apb_wr && paddr == ADDR_MODE) begin
         mode_reg <= pwdata[4:0];
      end
   end

   // dll enable stays as written until written back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dll_reg <= DLL_RST;
      end else if (apb_wr && paddr == ADDR_DLL) begin
         dll_reg <= pwdata[DLL_BIT]; // [R11]
      end
   end

   // self refresh abort enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_reg <= ABORT_RST;
      end else if (apb_wr && paddr == ADDR_SRCTL) begin
         abort_reg <= pwdata[ABORT_BIT];
      end
   end

   // read mux, sampled in the setup phase so prdata comes from a flop
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (paddr)
         ADDR_MODE: rdata_next[4:0] = mode_reg;
         ADDR_DLL: rdata_next[DLL_BIT] = dll_reg;
         ADDR_SRCTL: rdata_next[ABORT_BIT] = abort_reg;
         ADDR_STATUS: begin
            rdata_next[ST_SR_BIT] = sr_active;
            rdata_next[ST_REF_BIT] = ref_busy;
            rdata_next[ST_BUSY_BIT] = state_reg == ST_BURST;
            rdata_next[ST_DLL_BIT] = dll_reg;
         end
         ADDR_REFCNT: rdata_next[15:0] = ref_count;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         prdata <= rdata_next;
      end
   end

   // burst sequencer: eight beat slots, never cut short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         k_reg <= 3'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               k_reg <= 3'h0;
               if (accept) begin
                  state_reg <= ST_BURST;
               end
            end
            ST_BURST: begin
               k_reg <= k_reg + 3'h1;
               if (k_reg == LAST_BEAT) begin
                  state_reg <= ST_IDLE; // [R22]
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // burst attributes latched with the command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_col_reg <= 3'h0;
         rd_reg <= 1'b0;
         chop_reg <= 1'b0;
         ilv_reg <= 1'b0;
      end else if (accept) begin
         rd_reg <= cmd.op == OP_READ;
         chop_reg <= chop_next;
         ilv_reg <= mode_reg[BT_BIT]; // [R1]
         if (cmd.op == OP_WRITE && mode_reg[CRC_BIT] && fixed8) begin
            st_col_reg <= 3'h0; // [R10]
         end else begin
            st_col_reg <= cmd.col;
         end
      end
   end

   dbs_beat_gen u_gen (
      .start_col(st_col_reg),
      .beat_k(k_reg),
      .interleave(ilv_reg),
      .is_write(!rd_reg),
      .chop(chop_reg),
      .col(beat_col)
   );

   // beat output; chopped tail slots keep drivers off and data ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beat <= '0;
      end else begin
         beat.valid <= state_reg == ST_BURST;
         beat.rd <= rd_reg;
         beat.col <= beat_col;
         beat.drive <= (state_reg == ST_BURST) && rd_reg &&
                        (!chop_reg || k_reg < HALF_BEAT); // [R6]
         beat.keep <= (state_reg == ST_BURST) && !rd_reg &&
                       (!chop_reg || k_reg < HALF_BEAT); // [R7]
      end
   end

   // internal write start; only fixed BC4 pulls it in, on-the-fly never
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_timer_reg <= 8'h00;
      end else if (accept && cmd.op == OP_WRITE) begin
         wr_timer_reg <= fixed4 ? 8'(WBC4) : 8'(WBL8); // [R8] [R9]
      end else if (wr_timer_reg != 8'h00) begin
         wr_timer_reg <= wr_timer_reg - 8'h01;
      end
   end

   // pulse as the timer passes one; zero means no write pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_int_start <= 1'b0;
      end else begin
         wr_int_start <= wr_timer_reg == 8'h01;
      end
   end

   // self refresh only from idle; the engine owns refresh bookkeeping
   dbs_selfref #(
      .REF_CYCLES(REF_CYCLES),
      .SR_PERIOD(SR_PERIOD)
   ) u_sr (
      .pclk(pclk),
      .presetn(presetn),
      .sre(cmd.valid && cmd.op == OP_SRE && state_reg == ST_IDLE && !sr_active),
      .srx(cmd.valid && cmd.op == OP_SRX && sr_active),
      .ref_cmd(cmd.valid && cmd.op == OP_REF && !sr_active),
      .abort_en(abort_reg), // [R19]
      .sr_active(sr_active),
      .ref_busy(ref_busy),
      .abort_pulse(refresh_abort),
      .ref_count(ref_count)
   );

   // checks
   sequence rd_taken;
      accept && cmd.op == OP_READ;
   endsequence

   sequence wr_taken;
      accept && cmd.op == OP_WRITE;
   endsequence

   burst_type_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      accept |=> ilv_reg == $past(mode_reg[BT_BIT]))
      else $error("burst type not taken from mode bit");
   fixed_len_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (accept && !otf) |=> chop_reg == $past(fixed4))
      else $error("fixed burst length not applied");
   otf_sample_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (accept && otf) |=> chop_reg == !$past(cmd.bl8_sel))
      else $error("on-the-fly chop bit not sampled");
   seq_order_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (rd_taken and (!mode_reg[BT_BIT])) |-> ##6
      (beat.col == {~st_col_reg[2], st_col_reg[1:0]}))
      else $error("sequential upper half order wrong");
   ilv_order_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      (rd_taken and mode_reg[BT_BIT]) |-> ##4 (beat.col == (st_col_reg ^ 3'h2)))
      else $error("interleaved order wrong");
   chop_hiz_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (rd_taken and chop_next) |-> ##2 (beat.valid && beat.drive) [*4] ##1
      (beat.valid && !beat.drive) [*4])
      else $error("chopped read drives tail slots");
   wr_order_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      (beat.valid && !beat.rd && beat.keep) |-> beat.col[1:0] == $past(k_reg[1:0]))
      else $error("write beat order not from zero");
   wr_pull_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      (wr_taken and fixed4) |=> ##WBC4 wr_int_start)
      else $error("fixed BC4 internal write not pulled in");
   wr_otf_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      (wr_taken and (!fixed4)) |=> ##WBL8 wr_int_start)
      else $error("internal write not at BL8 timing");
   crc_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      (wr_taken and (mode_reg[CRC_BIT] && fixed8)) |-> ##2 beat.col == 3'h0)
      else $error("crc write burst not starting at zero");
   dll_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      (apb_wr && paddr == ADDR_DLL) |=> dll_en == $past(pwdata[DLL_BIT]))
      else $error("dll enable not following write");
   burst_whole_a: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
      accept |=> (!cmd_ready) [*8] ##1 beat.valid)
      else $error("burst cut short");

   // write chop spans two phases of four beats each
   sequence wr_chop_taken;
      accept && cmd.op == OP_WRITE && chop_next;
   endsequence

   sequence head_kept;
      (beat.valid && beat.keep) [*4];
   endsequence

   sequence tail_dropped;
      (beat.valid && !beat.keep) [*4];
   endsequence

   wr_tail_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      wr_chop_taken |-> ##2 head_kept ##1 tail_dropped)
      else $error("chopped write tail data not ignored");
   full_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (rd_taken and (!chop_next)) |-> ##2 (beat.valid && beat.drive) [*8])
      else $error("full read burst not driven");
   seq_first_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (rd_taken and (!mode_reg[BT_BIT])) |-> ##2 (beat.col == st_col_reg))
      else $error("sequential burst not starting at column");
   ilv_last_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      (rd_taken and mode_reg[BT_BIT]) |-> ##9 (beat.col == (st_col_reg ^ LAST_BEAT)))
      else $error("interleaved last beat wrong");
   otf_wr_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      (wr_taken and otf) |=> wr_timer_reg == 8'(WBL8))
      else $error("on-the-fly write timer pulled in");

   // short guards, each checked in the same or the next cycle
   wr_nodrive_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (beat.valid && !beat.rd) |-> !beat.drive)
      else $error("write beat turned output drivers on");
   refuse_rw_a: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
      (cmd.valid && is_rw && !cmd_ready) |=> $stable(st_col_reg) && $stable(rd_reg))
      else $error("refused command changed the burst");
   dll_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      !(apb_wr && paddr == ADDR_DLL) |=> $stable(dll_en))
      else $error("dll enable changed without a write");
   wr_once_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      wr_int_start |=> !wr_int_start)
      else $error("internal write start longer than one cycle");
   apb_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_setup && !pwrite) |=> prdata == $past(rdata_next))
      else $error("read data not held from setup");
endmodule
`default_nettype wire

// >>> inc/dbs_pkg.sv
// constants, types and field layout for the burst-order and dll-off block
// assumes a 100 MHz pclk and a single apb master
//
// Contract
// R1: MR0 A3 picks sequential or interleaved burst order.
// R2: MR0 A1:A0 picks fixed BC4, fixed BL8 or on-the-fly length.
// R3: on-the-fly mode samples A12/BC with each read or write command.
// R4: sequential read beats step low two bits from start, upper half inverts A2.
// R5: interleaved read beat k addresses start column XOR k.
// R6: chopped read drives four beats, output drivers off for the last four.
// R7: writes ignore A1 A0; BL8 writes ignore A2; chopped tail data ignored.
// R8: fixed BC4 starts the internal write two clocks earlier than BL8.
// R9: on-the-fly length keeps internal write at BL8 timing even when chopped.
// R10: write CRC with fixed BL8 forces write burst start column 000.
// R11: MR1 A0 at 0 disables the DLL until written back to 1.
// R12: controller idles, all banks precharged, termination off before DLL-off write.
// R13: controller waits tMOD, enters self refresh, waits tCKSRE before clock change.
// R14: controller changes clock only in self refresh, stable tCKSRX before exit.
// R15: controller keeps CKE high from exit until every tMOD elapses.
// R16: controller holds ODT low until tMOD if termination was on.
// R17: after tXS_FAST only ZQ calibration and restricted mode writes allowed.
// R18: other commands wait tXS after self refresh exit.
// R19: MR4 A9 aborts ongoing refresh at exit without counting it.
// R20: controller issues an extra refresh before re-entering self refresh.
// R21: controller waits tMOD after last mode write before next command; the bench issues its next command right after MODE and SRCTL writes.
// R22: a started burst runs to completion and cannot be interrupted.
// R23: controller sends deselects during tXS; reads and ODT wait tXSDLL.
`default_nettype none
package dbs_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_DLL = 8'h04;
   localparam logic [7:0] ADDR_SRCTL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_REFCNT = 8'h10;
   // field positions; mode fields kept at the mode register bit numbers, status bits numbered from 0
   localparam int BL_LSB = 0;
   localparam int BT_BIT = 3;
   localparam int CRC_BIT = 4;
   localparam int DLL_BIT = 0;
   localparam int ABORT_BIT = 9;
   localparam int ST_SR_BIT = 0;
   localparam int ST_REF_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_DLL_BIT = 3;
   // burst length codes
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;
   // reset values
   localparam logic [4:0] MODE_RST = 5'h00;
   localparam logic DLL_RST = 1'b1;
   localparam logic ABORT_RST = 1'b0;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_RFC_NS = 350;
   localparam int T_REFI_NS = 7800;
   localparam int REF_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFI_CYC = T_REFI_NS / CLK_PERIOD_NS;
   localparam int WR_PULL_IN = 2;
   localparam int BEATS = 8;
   localparam logic [2:0] LAST_BEAT = 3'h7;
   localparam logic [2:0] HALF_BEAT = 3'h4;

   typedef enum logic [4:0] {
      OP_READ = 5'h01,
      OP_WRITE = 5'h02,
      OP_SRE = 5'h04,
      OP_SRX = 5'h08,
      OP_REF = 5'h10
   } dbs_op_type;

   typedef struct packed {
      logic valid;
      dbs_op_type op;
      logic bl8_sel;
      logic [2:0] col;
   } dbs_cmd_type;

   typedef struct packed {
      logic valid;
      logic rd;
      logic drive;
      logic keep;
      logic [2:0] col;
   } dbs_beat_type;
endpackage
`default_nettype wire

// >>> src/dbs_beat_gen.sv
// column low-bit generator for one beat of a burst
// assumes start column and beat index are stable for the cycle
`default_nettype none
module dbs_beat_gen (
   input wire logic [2:0] start_col,
   input wire logic [2:0] beat_k,
   input wire logic interleave,
   input wire logic is_write,
   input wire logic chop,
   output logic [2:0] col
);
   import dbs_pkg::*;

   // writes count up from zero, chopped ones in the chosen half; reads follow burst type
   always_comb begin
      if (is_write) begin
         col = chop ? {start_col[2] ^ beat_k[2], beat_k[1:0]} : beat_k; // [R7]
      end else if (interleave) begin
         col = start_col ^ beat_k; // [R5]
      end else begin
         col = {start_col[2] ^ beat_k[2], 2'(start_col[1:0] + beat_k[1:0])}; // [R4]
      end
   end
endmodule
`default_nettype wire

// >>> src/dbs_selfref.sv
// self refresh state, refresh engine and abort-on-exit
// assumes sre/srx/ref pulses are legal commands from the controller
`default_nettype none
module dbs_selfref #(
   parameter int REF_CYCLES = 35,
   parameter int SR_PERIOD = 780
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sre,
   input wire logic srx,
   input wire logic ref_cmd,
   input wire logic abort_en,
   output logic sr_active,
   output logic ref_busy,
   output logic abort_pulse,
   output logic [15:0] ref_count
);
   import dbs_pkg::*;

   initial begin
      if (REF_CYCLES < 1 || REF_CYCLES > 65535 || SR_PERIOD < 2 || SR_PERIOD > 65535) begin
         $error("dbs_selfref: refresh timing out of range");
      end
   end

   logic [15:0] ref_timer_reg;
   logic [15:0] period_reg;
   logic do_abort;
   logic sr_tick;

   assign do_abort = srx && abort_en && ref_busy;
   assign sr_tick = sr_active && (period_reg == 16'h0000);

   // self refresh entry and exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_active <= 1'b0;
      end else if (sre) begin
         sr_active <= 1'b1;
      end else if (srx) begin
         sr_active <= 1'b0;
      end
   end

   // internal refresh interval while in self refresh
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_reg <= 16'h0000;
      end else if (sre || sr_tick) begin
         period_reg <= 16'(SR_PERIOD - 1);
      end else if (sr_active) begin
         period_reg <= period_reg - 16'h0001;
      end
   end

   // refresh engine; an abort drops the refresh without counting it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_busy <= 1'b0;
         ref_timer_reg <= 16'h0000;
         ref_count <= 16'h0000;
      end else if (do_abort) begin
         ref_busy <= 1'b0; // [R19]
      end else if (ref_busy) begin
         ref_timer_reg <= ref_timer_reg - 16'h0001;
         if (ref_timer_reg == 16'h0000) begin
            ref_busy <= 1'b0;
            ref_count <= ref_count + 16'h0001;
         end
      end else if (ref_cmd || sr_tick) begin
         ref_busy <= 1'b1;
         ref_timer_reg <= 16'(REF_CYCLES - 1);
      end
   end

   // one-cycle flag for the abort event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_pulse <= 1'b0;
      end else begin
         abort_pulse <= do_abort;
      end
   end

   abort_nocount_a: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
      do_abort |=> !ref_busy && $stable(ref_count) && abort_pulse)
      else $error("refresh abort counted or left busy");
endmodule
`default_nettype wire

// >>> verification/dbs_ctl_model.sv
// controller model: issues one-hot commands to the device
// assumes the bench calls its tasks from one process
`default_nettype none
module dbs_ctl_model #(
   parameter int T_MOD = 24,
   parameter int T_XS = 40,
   parameter int T_RFC = 16
) (
   input wire logic pclk,
   input wire logic cmd_ready,
   input wire logic sr_active,
   output var dbs_pkg::dbs_cmd_type cmd
);
   timeunit 1ns;
   timeprecision 100ps;
   import dbs_pkg::*;
   bit need_ref = 1'b0;
   // clock is never altered, so no tCKSRE or tCKSRX hazard
   initial cmd = '0;
   // no cke or odt pins here: cke never drops and odt stays low
   // one pulse; chk=0 sends without waiting, to provoke a refusal
   task automatic pulse(input dbs_op_type op, input logic bl8, input logic [2:0] col,
         input bit chk, output bit ok);
      int n;
      n = 0;
      // idle, no burst running, before any command except SRX, which waits for self refresh
      while (chk && n < 400 && !(op == OP_SRX ? sr_active : cmd_ready)) begin
         @(negedge pclk);
         n++;
      end
      ok = n < 400;
      @(posedge pclk);
      cmd <= '{valid: 1'b1, op: op, bl8_sel: bl8, col: col};
      @(posedge pclk);
      // released fields flip so stale values are never trusted
      cmd <= '{valid: 1'b0, op: op, bl8_sel: ~bl8, col: ~col};
   endtask
   // refresh bookkeeping kept apart so no task calls itself
   task automatic send(input dbs_op_type op, input logic bl8, input logic [2:0] col,
         input bit chk, output bit ok);
      bit ok_ref;
      ok_ref = 1'b1;
      if (op == OP_SRE && need_ref) begin
         pulse(OP_REF, 1'b0, 3'h0, 1'b1, ok_ref);
         need_ref = 1'b0;
         pause(T_RFC);
      end
      pulse(op, bl8, col, chk, ok);
      ok = ok && ok_ref;
      if (op == OP_SRX) need_ref = 1'b1;
      if (op == OP_REF) begin
         need_ref = 1'b0;
         pause(T_RFC);
      end
   endtask
   // deselects only: tMOD, tXS and tRFC gaps
   task automatic pause(input int n);
      repeat (n) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// bench for burst order, write timing, dll control and self refresh
// assumes the controller model is the only source of commands
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dbs_pkg::*;
   localparam int WR_DLY = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, cmd_ready, wr_int_start, dll_en, sr_active, refresh_abort, err;
   dbs_cmd_type cmd;
   dbs_beat_type beat;
   int error_cnt = 0;
   int n_tests = 0;
   bit ok;
   always #5 pclk = ~pclk;
   dbs_top #(.WR_BL8_DLY(WR_DLY), .REF_CYCLES(12), .SR_PERIOD(30)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd(cmd), .cmd_ready(cmd_ready), .beat(beat),
      .wr_int_start(wr_int_start), .dll_en(dll_en), .sr_active(sr_active),
      .refresh_abort(refresh_abort));
   dbs_ctl_model u_ctl (.pclk(pclk), .cmd_ready(cmd_ready), .sr_active(sr_active),
      .cmd(cmd));
   task automatic stop_test();
      if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         check(32'h0, 32'h1);
         stop_test();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic issue(input dbs_op_type op, input logic bl8, input logic [2:0] c,
         input bit chk);
      u_ctl.send(op, bl8, c, chk, ok);
      if (!ok) begin
         check(32'h0, 32'h1);
         stop_test();
      end
   endtask
   // one burst: beat columns, driver and keep flags, internal write start
   task automatic burst(input logic [4:0] mode, input logic wr, input logic bl8,
         input logic [2:0] c);
      logic chop, live;
      logic [2:0] k, e;
      int first;
      chop = mode[1:0] == BL_FIX4 || (mode[1:0] == BL_OTF && !bl8);
      first = 0;
      apb(1'b1, ADDR_MODE, {27'h0, mode});
      issue(wr ? OP_WRITE : OP_READ, bl8, c, 1'b1);
      for (int i = 0; i < 12; i++) begin
         @(posedge pclk);
         #1;
         k = i[2:0];
         live = !chop || !k[2];
         if (wr_int_start === 1'b1 && first == 0) first = i + 1;
         if (i < 8) begin
            e = wr ? (chop ? {c[2], k[1:0]} : k) :
               (mode[3] ? c ^ k : {c[2] ^ k[2], c[1:0] + k[1:0]});
            check({beat.valid, beat.rd, beat.drive, beat.keep},
               {1'b1, !wr, !wr && live, wr && live});
            if (live) check({29'h0, beat.col}, {29'h0, e});
         end
      end
      check(first, wr ? (mode[1:0] == BL_FIX4 ? WR_DLY - 2 : WR_DLY) : 0);
   endtask
   // enter, refuse a read, exit while a refresh runs, count it or not
   task automatic sr_cycle(input logic ab);
      logic [31:0] c0;
      int n, p;
      n = 0;
      p = 0;
      issue(OP_SRE, 1'b0, 3'h0, 1'b1);
      #1;
      check({sr_active, cmd_ready}, 2'b10);
      issue(OP_READ, 1'b1, 3'h0, 1'b0);
      repeat (9) begin
         @(posedge pclk);
         #1;
         if (beat.valid !== 1'b0) p++;
      end
      check(p, 0);
      apb(1'b0, ADDR_REFCNT, 32'h0);
      c0 = rd;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end while (rd[1] !== 1'b1 && n < 40);
      check(n < 40, 1'b1);
      issue(OP_SRX, 1'b0, 3'h0, 1'b1);
      // the abort flag stands only in the cycle right after the exit edge
      repeat (4) begin
         #1;
         if (refresh_abort === 1'b1) p++;
         @(posedge pclk);
      end
      check(p, ab);
      u_ctl.pause(u_ctl.T_XS);
      rchk(ADDR_STATUS, 32'h0);
      rchk(ADDR_REFCNT, c0 + (ab ? 32'h0 : 32'h1));
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      check(dll_en, 1'b1);
      rchk(ADDR_MODE, 32'h0);
      rchk(ADDR_DLL, 32'h1);
      rchk(ADDR_STATUS, 32'h8);
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      for (int c = 0; c < 8; c++) begin
         burst(5'h00, 1'b0, 1'b1, c[2:0]);
         burst(5'h08, 1'b0, 1'b1, c[2:0]);
      end
      burst(5'h02, 1'b0, 1'b1, 3'h5);
      burst(5'h0A, 1'b0, 1'b1, 3'h3);
      burst(5'h01, 1'b0, 1'b0, 3'h6);
      burst(5'h01, 1'b0, 1'b1, 3'h6);
      burst(5'h00, 1'b1, 1'b0, 3'h5);
      burst(5'h02, 1'b1, 1'b1, 3'h6);
      burst(5'h01, 1'b1, 1'b0, 3'h5);
      burst(5'h10, 1'b1, 1'b1, 3'h7);
      apb(1'b1, ADDR_DLL, 32'h0);
      #1;
      check(dll_en, 1'b0);
      rchk(ADDR_STATUS, 32'h0);
      u_ctl.pause(u_ctl.T_MOD);
      apb(1'b1, ADDR_SRCTL, 32'h0);
      sr_cycle(1'b0);
      apb(1'b1, ADDR_SRCTL, 32'h200);
      sr_cycle(1'b1);
      rchk(ADDR_DLL, 32'h0);
      apb(1'b1, ADDR_DLL, 32'h1);
      #1;
      check(dll_en, 1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
